// *** logic/ttm_params.svh ***
// Constants of the three timer module: map, fields, codes, resets.
// Assumes inclusion by its bare name from the package and the top module.
// ==========================================================
// Functional notes
// - Three separate 16-bit up/down timers: one core, two auxiliary.
// - Each timer picks timer, gated, counter or incremental mode.
// - Timer mode counts prescaled CPU clock pulses.
// - Select 000b divides by 8, each step doubles, 111b by 1024.
// - Same prescaler serves core and auxiliary timer/gated modes.
// - Counter mode advances on selected edges of the external input.
// - Gated mode counts prescaled clocks only while the gate is active.
// - One input pin per timer acts as gate or count clock.
// - Direction set by software bit, optionally flipped by direction pin.
// - Incremental mode derives count and direction from A and B.
// - Core toggle latch flips on every core overflow or underflow.
// - When enabled the core toggle latch drives the output pin.
// - Core toggle latch transitions may clock either auxiliary timer.
// - Auxiliary timer may instead act as core capture or reload register.
// - Capture or reload auxiliary timers never count.
// - Capture copies the core count on a selected own-pin edge.
// - Reload loads core from auxiliary on pin edge or latch transition.
// - Two reloads on opposite latch transitions give hands-free PWM.
`ifndef TTM_PARAMS_SVH
`define TTM_PARAMS_SVH

// ==========================================================
// Widths
`define TTM_DW 16
`define TTM_CW 10
`define TTM_PW 10
`define TTM_AW 4

// ==========================================================
// Register word addresses
`define TTM_ADDR_CTL_CORE 4'h0
`define TTM_ADDR_CTL_A 4'h1
`define TTM_ADDR_CTL_B 4'h2
`define TTM_ADDR_CNT_CORE 4'h3
`define TTM_ADDR_CNT_A 4'h4
`define TTM_ADDR_CNT_B 4'h5

// ==========================================================
// Control field positions
`define TTM_F_SEL_HI 2
`define TTM_F_SEL_LO 0
`define TTM_F_MODE_HI 5
`define TTM_F_MODE_LO 3
`define TTM_F_RUN 6
`define TTM_F_DOWN 7
`define TTM_F_EXTDIR 8
`define TTM_F_TOUT 9
`define TTM_F_TL 10

// ==========================================================
// Mode codes
`define TTM_MODE_TIMER 3'h0
`define TTM_MODE_COUNTER 3'h1
`define TTM_MODE_GATE_LO 3'h2
`define TTM_MODE_GATE_HI 3'h3
`define TTM_MODE_RELOAD 3'h4
`define TTM_MODE_CAPTURE 3'h5
`define TTM_MODE_INCR 3'h6

// ==========================================================
// Reset values and prescaler base exponent (divide by 8)
`define TTM_CTL_RST 10'h000
`define TTM_CNT_RST 16'h0000
`define TTM_PS_BASE 4'h3

`endif

// *** logic/ttm_pkg.sv ***
// Types of the three timer module.
// Assumes ttm_params.svh is on the include path.
`include "ttm_params.svh"

package ttm_pkg;

  // ==========================================================
  // Pin bundle: index 0 core, 1 aux a, 2 aux b
  typedef struct packed {
    logic [2:0] gate_count_input_pin;
    logic [2:0] direction_input_pin;
  } ttm_pins_s;

  // ==========================================================
  // Whole module state
  typedef struct packed {
    logic [2:0][`TTM_CW-1:0] ctl;
    logic [2:0][`TTM_DW-1:0] cnt;
    logic core_toggle_latch;
    logic [`TTM_PW-1:0] presc;
    ttm_pins_s s1;
    ttm_pins_s s2;
    ttm_pins_s s3;
    logic [`TTM_DW-1:0] rdata;
    logic tout;
  } ttm_state_s;

endpackage : ttm_pkg

// *** logic/ttm_top.sv ***
// Three timer module: core timer plus two auxiliary timers.
// Assumes pins synchronous to core_clk and a one-cycle strobe register port.
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
`include "ttm_params.svh"

module ttm_top
  import ttm_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [`TTM_AW-1:0] reg_addr,
  input wire logic [`TTM_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`TTM_DW-1:0] reg_rdata,
  input ttm_pins_s ext_pins,
  output logic toggle_output_pin
);

  // ==========================================================
  // Constants

  localparam logic [`TTM_PW-1:0] PS_ONE = `TTM_PW'(1);
  localparam logic [`TTM_DW-1:0] CNT_ONE = `TTM_DW'(1);
  localparam logic [`TTM_DW-1:0] CNT_MAX = {`TTM_DW{1'b1}};
  localparam logic [`TTM_DW-1:0] CNT_MIN = {`TTM_DW{1'b0}};

  // Reset image of the whole state
  localparam ttm_state_s ST_RST = '{
    ctl: {3{`TTM_CTL_RST}},
    cnt: {3{`TTM_CNT_RST}},
    core_toggle_latch: 1'b0,
    presc: '0,
    s1: '0,
    s2: '0,
    s3: '0,
    rdata: '0,
    tout: 1'b0
  };

  // ==========================================================
  // Helpers

  // Tick once every 8 << sel cycles of the free prescaler
  function automatic logic presc_tick(
    input logic [`TTM_PW-1:0] p,
    input logic [2:0] sel
  );
    logic [3:0] sh;
    logic [`TTM_PW-1:0] m;
    sh = {1'b0, sel} + `TTM_PS_BASE;
    m = (PS_ONE << sh) - PS_ONE;
    return (p & m) == m;
  endfunction : presc_tick

  // Edge select: bit 0 rising, bit 1 falling, both for either
  function automatic logic edge_hit(
    input logic cur,
    input logic prev,
    input logic [1:0] sel
  );
    return (sel[0] & cur & ~prev) | (sel[1] & ~cur & prev);
  endfunction : edge_hit

  // One step up or down, wrapping at the ends
  function automatic logic [`TTM_DW-1:0] step(
    input logic [`TTM_DW-1:0] v,
    input logic go_up
  );
    return go_up ? v + CNT_ONE : v - CNT_ONE;
  endfunction : step

  // Register write decode
  function automatic logic wr_hit(
    input logic wr,
    input logic [`TTM_AW-1:0] a,
    input logic [`TTM_AW-1:0] target
  );
    return wr & (a == target);
  endfunction : wr_hit

  // ==========================================================
  // State

  ttm_state_s st;
  ttm_state_s next_st;

  logic [2:0][2:0] mode;
  logic [2:0][2:0] sel;
  logic [2:0] tick;
  logic [2:0] up;
  logic [2:0] pin_edge;
  logic [2:0] reload;
  logic [2:0] capture;
  logic ovf;
  logic next_tl;
  logic tl_rise;
  logic tl_fall;

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    mode = '0;
    sel = '0;
    tick = '0;
    up = '0;
    pin_edge = '0;
    reload = '0;
    capture = '0;

    // Sample, then compare two clean stages for edges
    next_st.s1 = ext_pins;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;

    // Free prescaler shared by all three timers
    next_st.presc = st.presc + PS_ONE;

    // Per timer count source and direction
    for (int i = 0; i < 3; i++) begin
      mode[i] = st.ctl[i][`TTM_F_MODE_HI:`TTM_F_MODE_LO];
      sel[i] = st.ctl[i][`TTM_F_SEL_HI:`TTM_F_SEL_LO];
      pin_edge[i] = edge_hit(st.s2.gate_count_input_pin[i],
        st.s3.gate_count_input_pin[i], sel[i][1:0]);
      up[i] = ~st.ctl[i][`TTM_F_DOWN] ^
        (st.ctl[i][`TTM_F_EXTDIR] & st.s2.direction_input_pin[i]);
      case (mode[i])
        `TTM_MODE_TIMER: begin
          tick[i] = presc_tick(st.presc, sel[i]);
        end
        `TTM_MODE_GATE_LO: begin
          tick[i] = presc_tick(st.presc, sel[i]) &
            ~st.s2.gate_count_input_pin[i];
        end
        `TTM_MODE_GATE_HI: begin
          tick[i] = presc_tick(st.presc, sel[i]) &
            st.s2.gate_count_input_pin[i];
        end
        `TTM_MODE_COUNTER: begin
          // Aux timers with sel bit 2 take the latch later on
          tick[i] = pin_edge[i] & ~(sel[i][2] & (i != 0));
        end
        `TTM_MODE_INCR: begin
          // A on the gate pin, B on the direction pin
          tick[i] = (sel[i][0] & (st.s2.gate_count_input_pin[i] ^
            st.s3.gate_count_input_pin[i])) |
            (sel[i][1] & (st.s2.direction_input_pin[i] ^
            st.s3.direction_input_pin[i]));
          up[i] = (st.s2.gate_count_input_pin[i] ^
            st.s3.direction_input_pin[i]) ^
            st.ctl[i][`TTM_F_DOWN];
        end
        default: begin
          // Capture, reload and the spare code hold the count
          tick[i] = 1'b0;
        end
      endcase
      tick[i] = tick[i] & st.ctl[i][`TTM_F_RUN];
    end

    // Core wrap at either end flips the latch
    ovf = tick[0] & (up[0] ? (st.cnt[0] == CNT_MAX) :
      (st.cnt[0] == CNT_MIN));
    // Hardware flip wins over a software write in the same cycle
    if (ovf) begin
      next_tl = ~st.core_toggle_latch;
    end else if (wr_hit(reg_wr, reg_addr, `TTM_ADDR_CTL_CORE)) begin
      next_tl = reg_wdata[`TTM_F_TL];
    end else begin
      next_tl = st.core_toggle_latch;
    end
    next_st.core_toggle_latch = next_tl;
    // Transitions seen the same cycle, so reload lands on the wrap
    tl_rise = next_tl & ~st.core_toggle_latch;
    tl_fall = ~next_tl & st.core_toggle_latch;

    // Aux timers: latch clocking, reload and capture triggers
    for (int i = 1; i < 3; i++) begin
      if ((mode[i] == `TTM_MODE_COUNTER) && sel[i][2]) begin
        tick[i] = st.ctl[i][`TTM_F_RUN] &
          ((sel[i][0] & tl_rise) | (sel[i][1] & tl_fall));
      end
      if (mode[i] == `TTM_MODE_RELOAD) begin
        reload[i] = sel[i][2] ?
          ((sel[i][0] & tl_rise) | (sel[i][1] & tl_fall)) :
          pin_edge[i];
      end
      if (mode[i] == `TTM_MODE_CAPTURE) begin
        capture[i] = pin_edge[i];
      end
    end

    // Core count: reload beats counting, aux a beats aux b
    if (reload[1]) begin
      next_st.cnt[0] = st.cnt[1];
    end else if (reload[2]) begin
      next_st.cnt[0] = st.cnt[2];
    end else if (tick[0]) begin
      next_st.cnt[0] = step(st.cnt[0], up[0]);
    end

    // Aux counts: count or capture the pre-update core value
    for (int i = 1; i < 3; i++) begin
      if (capture[i]) begin
        next_st.cnt[i] = st.cnt[0];
      end else if (tick[i]) begin
        next_st.cnt[i] = step(st.cnt[i], up[i]);
      end
    end

    // Software writes to a count win over hardware
    if (wr_hit(reg_wr, reg_addr, `TTM_ADDR_CNT_CORE)) begin
      next_st.cnt[0] = reg_wdata;
    end
    if (wr_hit(reg_wr, reg_addr, `TTM_ADDR_CNT_A)) begin
      next_st.cnt[1] = reg_wdata;
    end
    if (wr_hit(reg_wr, reg_addr, `TTM_ADDR_CNT_B)) begin
      next_st.cnt[2] = reg_wdata;
    end

    // Control writes; latch bit lives apart in the core word
    if (wr_hit(reg_wr, reg_addr, `TTM_ADDR_CTL_CORE)) begin
      next_st.ctl[0] = reg_wdata[`TTM_CW-1:0];
    end
    if (wr_hit(reg_wr, reg_addr, `TTM_ADDR_CTL_A)) begin
      next_st.ctl[1] = reg_wdata[`TTM_CW-1:0];
    end
    if (wr_hit(reg_wr, reg_addr, `TTM_ADDR_CTL_B)) begin
      next_st.ctl[2] = reg_wdata[`TTM_CW-1:0];
    end

    // Output pin follows the latch when enabled
    next_st.tout = next_tl & next_st.ctl[0][`TTM_F_TOUT];

    // Read data stands one cycle only, zero otherwise
    next_st.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        `TTM_ADDR_CTL_CORE: begin
          next_st.rdata = {5'h00, st.core_toggle_latch, st.ctl[0]};
        end
        `TTM_ADDR_CTL_A: begin
          next_st.rdata = {6'h00, st.ctl[1]};
        end
        `TTM_ADDR_CTL_B: begin
          next_st.rdata = {6'h00, st.ctl[2]};
        end
        `TTM_ADDR_CNT_CORE: begin
          next_st.rdata = st.cnt[0];
        end
        `TTM_ADDR_CNT_A: begin
          next_st.rdata = st.cnt[1];
        end
        `TTM_ADDR_CNT_B: begin
          next_st.rdata = st.cnt[2];
        end
        default: begin
          next_st.rdata = '0;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flops
  assign reg_rdata = st.rdata;
  assign toggle_output_pin = st.tout;

endmodule : ttm_top

// *** sim/ttm_sensor.sv ***
// Far-side pin model: gate/count and direction pins of the three timers.
// Assumes the bench calls its tasks; pins move just after core_clk rises.
`timescale 1ns/10ps

module ttm_sensor
  import ttm_pkg::*;
(
  input wire logic core_clk,
  output ttm_pins_s pins
);
  // ==========================================================
  // Quadrature tables, forward order after state 00
  localparam logic [3:0] FA = 4'h3;
  localparam logic [3:0] FB = 4'h6;

  // Pins start low and hold their last level between bursts
  initial pins = '0;

  // One level on both pins of a timer, held past the sync stages
  task automatic put(input int i, input logic a, input logic b);
    @(posedge core_clk);
    pins.gate_count_input_pin[i] <= a;
    pins.direction_input_pin[i] <= b;
    repeat (2) @(posedge core_clk);
  endtask : put

  // Count pulses on the gate/count pin
  task automatic pulse(input int i, input int n);
    repeat (n) begin
      put(i, 1'b1, pins.direction_input_pin[i]);
      put(i, 1'b0, pins.direction_input_pin[i]);
    end
  endtask : pulse

  // Whole sensor cycles; reverse swaps the two tracks
  task automatic quad(input int i, input int n, input logic fwd);
    repeat (n) begin
      for (int k = 0; k < 4; k++) begin
        if (fwd) begin
          put(i, FA[k], FB[k]);
        end else begin
          put(i, FB[k], FA[k]);
        end
      end
    end
  endtask : quad
endmodule : ttm_sensor

// *** sim/ttm_top_properties.sv ***
// Port checker of the three timer module.
// Assumes a bind to ttm_top; control words are shadowed from bus writes.
`timescale 1ns/10ps
`include "ttm_params.svh"

module ttm_top_properties
  import ttm_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [`TTM_AW-1:0] reg_addr,
  input wire logic [`TTM_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`TTM_DW-1:0] reg_rdata,
  input ttm_pins_s ext_pins,
  input wire logic toggle_output_pin
);
  // ==========================================================
  // Shadow of control words; latch bit left out, hardware moves it
  logic [2:0][`TTM_CW-1:0] sh;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sh <= '0;
    end else if (reg_wr && reg_addr < 4'h3) begin
      sh[reg_addr] <= reg_wdata[`TTM_CW-1:0];
    end
  end

  default clocking @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // Bus and readback
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_rd_unmapped;
    reg_rd && reg_addr > 4'h5 |=> reg_rdata == '0;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  property p_ctl_core;
    reg_rd && reg_addr == 4'h0 |=> reg_rdata[15:11] == '0 && reg_rdata[9:0] == $past(sh[0]);
  endproperty
  a_ctl_core: assert property (p_ctl_core) else $error("core control readback");
  property p_ctl_a;
    reg_rd && reg_addr == 4'h1 |=> reg_rdata == {6'h00, $past(sh[1])};
  endproperty
  a_ctl_a: assert property (p_ctl_a) else $error("aux a control readback");
  property p_ctl_b;
    reg_rd && reg_addr == 4'h2 |=> reg_rdata == {6'h00, $past(sh[2])};
  endproperty
  a_ctl_b: assert property (p_ctl_b) else $error("aux b control readback");
  // Pin low two cycles after the output enable is cleared
  property p_tout_off;
    !sh[0][9] && !$past(sh[0][9]) |-> !toggle_output_pin;
  endproperty
  a_tout_off: assert property (p_tout_off) else $error("toggle pin high while disabled");
  // Stopped core with no reload source keeps a written value
  property p_cnt_core;
    reg_wr && reg_addr == 4'h3 && !sh[0][6] && sh[1][5:3] != `TTM_MODE_RELOAD &&
      sh[2][5:3] != `TTM_MODE_RELOAD ##2 reg_rd && reg_addr == 4'h3 |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_cnt_core: assert property (p_cnt_core) else $error("stopped core count moved");
  // Capture register never counts
  property p_cnt_capt;
    reg_wr && reg_addr == 4'h5 && sh[2][5:3] == `TTM_MODE_CAPTURE ##2 reg_rd && reg_addr == 4'h5
      |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_cnt_capt: assert property (p_cnt_capt) else $error("capture register moved");
endmodule : ttm_top_properties

// *** sim/ttm_top_tb.sv ***
// Self-checking bench of the three timer module with its pin model.
// Assumes ttm_pkg compiled first; reads are scored in the cycle after.
`timescale 1ns/10ps
`include "ttm_params.svh"

module ttm_top_tb
  import ttm_pkg::*;
;
  localparam logic [15:0] RUN = 16'h0040;
  localparam logic [15:0] DN = 16'h0080;
  localparam logic [15:0] EXD = 16'h0100;
  localparam logic [15:0] TOE = 16'h0200;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = '0;
  logic [15:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  ttm_pins_s ext_pins;
  logic toggle_output_pin;
  logic rd_seen = 1'b0;
  logic [15:0] v;
  logic [15:0] cap;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [15:0] exp_q[$];
  logic [15:0] msk_q[$];
  string nm_q[$];

  always #12.5 core_clk = ~core_clk;

  ttm_top ttm_top_i (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_pins(ext_pins),
    .toggle_output_pin(toggle_output_pin));
  ttm_sensor ttm_sensor_i (.core_clk(core_clk), .pins(ext_pins));

  // ==========================================================
  // Bus tasks and scoring
  function automatic logic [15:0] md(input logic [2:0] m, input logic [2:0] s);
    return {10'h000, m, s};
  endfunction : md

  task automatic final_report();
    if (n_fail == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Expectation noted as the strobe goes out
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m, input string nm);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    msk_q.push_back(m);
    nm_q.push_back(nm);
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask : rd

  // Exact run window: prescaler phase cannot change the tick count
  // A core control write also loads the latch, so the stop word can keep it set
  task automatic meas(input int t, input logic [15:0] c, input logic [15:0] w, input int n,
    input logic tl = 1'b0);
    wr(4'(t + 3), c);
    wr(4'(t), w | RUN);
    repeat (n - 2) @(posedge core_clk);
    wr(4'(t), w | {5'h00, tl, 10'h000});
  endtask : meas

  // Read data stand one cycle only, so score them there; cycle ceiling
  always @(posedge core_clk) begin
    if (rd_seen) begin
      v = msk_q.pop_front();
      chk(nm_q.pop_front(), exp_q.pop_front() & v, reg_rdata & v);
    end
    rd_seen <= reg_rd;
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      final_report();
    end
  end

  // ==========================================================
  // Scenarios
  initial begin
    void'($urandom(37540));
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    wr(4'h9, 16'hffff);
    for (int a = 0; a < 10; a++) begin
      rd(4'(a), 16'h0000, 16'hffff, "reset");
    end
    // Every divisor on every timer, odd codes counting down
    for (int t = 0; t < 3; t++) begin
      for (int s = 0; s < 8; s++) begin
        meas(t, 16'h0000, 16'(s) | (s[0] ? DN : 16'h0000), 3 * (8 << s));
        rd(4'(t + 3), s[0] ? 16'hfffd : 16'h0003, 16'hffff, "prescale");
      end
    end
    // Both gate polarities at both levels
    for (int i = 0; i < 4; i++) begin
      ttm_sensor_i.put(i / 2, i[0], 1'b0);
      meas(i / 2, 16'h0000, md(i < 2 ? `TTM_MODE_GATE_HI : `TTM_MODE_GATE_LO, 3'h0), 24);
      rd(4'(i / 2 + 3), (i[0] ^ (i > 1)) ? 16'h0003 : 16'h0000, 16'hffff, "gated");
    end
    // Rising edges counted, direction pin turns it down
    ttm_sensor_i.put(2, 1'b0, 1'b1);
    wr(4'h5, 16'h0000);
    wr(4'h2, md(`TTM_MODE_COUNTER, 3'h1) | EXD | RUN);
    ttm_sensor_i.pulse(2, 5);
    repeat (4) @(posedge core_clk);
    wr(4'h2, 16'h0000);
    rd(4'h5, 16'hfffb, 16'hffff, "counter");
    // Three cycles forward, one back
    ttm_sensor_i.put(0, 1'b0, 1'b0);
    wr(4'h3, 16'h0000);
    wr(4'h0, md(`TTM_MODE_INCR, 3'h3) | RUN);
    ttm_sensor_i.quad(0, 3, 1'b1);
    ttm_sensor_i.quad(0, 1, 1'b0);
    repeat (4) @(posedge core_clk);
    wr(4'h0, 16'h0000);
    rd(4'h3, 16'h0008, 16'hffff, "incremental");
    // One wrap: latch, pin and cascaded aux count
    wr(4'h1, md(`TTM_MODE_COUNTER, 3'h5) | RUN);
    meas(0, 16'hfffe, TOE, 24, 1'b1);
    rd(4'h3, 16'h0001, 16'hffff, "wrap");
    rd(4'h0, 16'h0600, 16'hffff, "latch");
    rd(4'h4, 16'h0001, 16'hffff, "cascade");
    chk("toggle pin", 16'h0001, {15'h0000, toggle_output_pin});
    // Alternate reloads on both latch transitions
    wr(4'h0, 16'h0000);
    wr(4'h4, 16'hfffd);
    wr(4'h5, 16'hffff);
    wr(4'h1, md(`TTM_MODE_RELOAD, 3'h5));
    wr(4'h2, md(`TTM_MODE_RELOAD, 3'h6));
    meas(0, 16'hfffe, 16'h0000, 40);
    rd(4'h3, 16'hffff, 16'hffff, "pwm");
    rd(4'h0, 16'h0000, 16'h0400, "pwm latch");
    rd(4'h4, 16'hfffd, 16'hffff, "reload hold");
    // Capture of a random stopped core value
    cap = 16'($urandom);
    wr(4'h1, 16'h0000);
    wr(4'h2, md(`TTM_MODE_CAPTURE, 3'h1));
    wr(4'h3, cap);
    rd(4'h3, cap, 16'hffff, "core write");
    wr(4'h5, 16'h0000);
    rd(4'h5, 16'h0000, 16'hffff, "capture idle");
    ttm_sensor_i.pulse(2, 1);
    rd(4'h5, cap, 16'hffff, "capture");
    // Falling pin edge reloads the stopped core from aux a
    cap = 16'($urandom);
    wr(4'h2, 16'h0000);
    wr(4'h4, cap);
    wr(4'h1, md(`TTM_MODE_RELOAD, 3'h2));
    ttm_sensor_i.pulse(1, 1);
    rd(4'h3, cap, 16'hffff, "pin reload");
    // Mid-run reset clears counts, control and latch
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(4'h3, 16'h0000, 16'hffff, "mid reset count");
    rd(4'h0, 16'h0000, 16'hffff, "mid reset latch");
    repeat (2) @(posedge core_clk);
    final_report();
  end
endmodule : ttm_top_tb

bind ttm_top ttm_top_properties ttm_top_properties_i (.core_clk(core_clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ext_pins(ext_pins), .toggle_output_pin(toggle_output_pin));
